// *** link_enh_chk.sv ***
module link_enh_chk (
    input wire logic clk, // Clock
    input wire logic rst, // Reset
    input wire logic [31:0] cfgRdata, // Read data
    input wire logic phyEnhanceGate, // Gate
    input wire logic retriesCleared, // Retries zero
    input wire logic lpsSet, // Set request
    input wire logic linkPowerStatus, // Power status
    input wire logic txOutOfOrderDisable, // No pipelining
    input wire logic outValid, // Link valid
    input wire logic outReady, // Link ready
    input wire logic outLast, // Link last
    input wire logic outError, // Abort
    input wire logic txUnderrun, // Underrun
    input wire logic storeForward // Whole packets
);
    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    a_reserved_high: assert property (cfgRdata[31:16] == 16'h0000)
        else $error("upper bits set");
    a_low_zero: assert property (cfgRdata[11:0] == 12'h000)
        else $error("low bits set");
    a_gate_pipe: assert property (!$past(phyEnhanceGate) |-> !txOutOfOrderDisable)
        else $error("ungated pipelining");
    a_gate_store: assert property (!$past(phyEnhanceGate) |-> storeForward)
        else $error("ungated threshold");
    a_retry_store: assert property ($past(retriesCleared) |-> storeForward)
        else $error("retries ignored");
    a_lps_set: assert property (lpsSet |=> linkPowerStatus)
        else $error("power status not set");
    a_underrun_pair: assert property (txUnderrun == outError)
        else $error("underrun without abort");
    a_underrun_fallback: assert property (txUnderrun |=> !txUnderrun && storeForward)
        else $error("no fallback");
    c_underrun: cover property (txUnderrun);
    c_packet: cover property (outValid && outReady && outLast);
    c_gate_off: cover property (!phyEnhanceGate);
endmodule : link_enh_chk

bind link_enhancement_control link_enh_chk chk (.clk(clk), .rst(rst), .cfgRdata(cfgRdata),
    .phyEnhanceGate(phyEnhanceGate), .retriesCleared(retriesCleared), .lpsSet(lpsSet),
    .linkPowerStatus(linkPowerStatus), .txOutOfOrderDisable(txOutOfOrderDisable),
    .outValid(outValid), .outReady(outReady), .outLast(outLast), .outError(outError),
    .txUnderrun(txUnderrun), .storeForward(storeForward));

// *** link_enh_pkg.sv ***
package link_enh_pkg;

    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam logic [7:0] LINK_ENH_CTRL_OFFSET = 8'hf4;
    localparam logic [31:0] LINK_ENH_CTRL_RESET = 32'h0000_4000;
    localparam logic [15:0] LINK_ENH_CTRL_WR_MASK = 16'hf000;
    localparam logic [15:0] RESERVED_HIGH_VALUE = 16'h0000;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int TX_OOO_DISABLE_BIT = 15;
    localparam int DRAFT_ENABLE_BIT = 14;
    localparam int TX_THRESH_LSB = 12;
    localparam int TX_THRESH_MSB = 13;
    localparam int RESERVED_BIT11 = 11;

    // ****************************************************************
    // Transmit threshold field
    // ****************************************************************
    typedef enum logic [1:0] {
        THRESH_4K,
        THRESH_1K7,
        THRESH_1K,
        THRESH_512
    } tx_thresh_t;

    localparam int BYTE_COUNT_W = 13;
    localparam logic [12:0] THRESH_4K_BYTES = 13'h1000;
    localparam logic [12:0] THRESH_1K7_BYTES = 13'h06a4;
    localparam logic [12:0] THRESH_1K_BYTES = 13'h0400;
    localparam logic [12:0] THRESH_512_BYTES = 13'h0200;
    localparam logic [12:0] BYTES_PER_WORD = 13'h0004;
    localparam logic [12:0] BYTE_COUNT_MAX = 13'h1fff;

    // ****************************************************************
    // Data path
    // ****************************************************************
    localparam int TX_WORD_W = 32;
    localparam int TX_FIFO_DEPTH = 16;
    localparam int PKT_COUNT_W = 6;

    function automatic logic [12:0] thresh_bytes(input tx_thresh_t code);
        unique case (code)
            THRESH_4K: thresh_bytes = THRESH_4K_BYTES;
            THRESH_1K7: thresh_bytes = THRESH_1K7_BYTES;
            THRESH_1K: thresh_bytes = THRESH_1K_BYTES;
            THRESH_512: thresh_bytes = THRESH_512_BYTES;
        endcase
    endfunction : thresh_bytes

endpackage : link_enh_pkg

// *** link_enhancement_control.sv ***
// Contract
// - Enhancements act only while phy gate set
// - Loaded by software write or EEPROM
// - Bits 31-16 read as zero
// - Bit 15 stops out-of-order transmit pipelining
// - Draft bit lets clear write drop power status
// - Draft bit allows receive status bit 9
// - Threshold codes: 4K, 1.7K, 1K, 512
// - After underrun, retry uses store-and-forward
// - Start at threshold or whole packet buffered
// - Underrun signalled, then whole packet held
// - 4K threshold sends only complete packets
// - Cleared retries register forces store-and-forward
// - Bit 11 reads as zero
module link_enhancement_control
    import link_enh_pkg::*;
#(
    parameter int FIFO_DEPTH = TX_FIFO_DEPTH
) (
    input wire logic clk, // Host bus clock
    input wire logic rst, // Synchronous reset
    input wire logic cfgWrite, // Config write strobe
    input wire logic cfgRead, // Config read strobe
    input wire logic [7:0] cfgAddr, // Config byte offset
    input wire logic [3:0] cfgByteEn, // Config byte enables
    input wire logic [31:0] cfgWdata, // Config write data
    output logic [31:0] cfgRdata, // Config read data
    input wire logic eepromLoad, // EEPROM autoload strobe
    input wire logic [31:0] eepromData, // EEPROM autoload word
    input wire logic phyEnhanceGate, // Host control gate bit
    input wire logic retriesCleared, // Transmit retries register zero
    input wire logic lpsSet, // Power status set request
    input wire logic lpsClearWrite, // Power status clear write
    output logic linkPowerStatus, // Link power status
    output logic txOutOfOrderDisable, // Pipelining disabled
    output logic rxStatusBit9Enable, // Receive status bit 9 allowed
    input wire logic inValid, // Transmit word valid
    output logic inReady, // Transmit word accepted
    input wire logic [TX_WORD_W-1:0] inData, // Transmit word
    input wire logic inLast, // End of packet word
    output logic outValid, // Link word valid
    input wire logic outReady, // Link takes word
    output logic [TX_WORD_W-1:0] outData, // Link word
    output logic outLast, // Link end of packet
    output logic outError, // Packet aborted pulse
    output logic txUnderrun, // Underrun pulse
    output logic storeForward // Store-and-forward in force
);

    initial begin
        if (FIFO_DEPTH < 2) begin
            $error("link_enhancement_control needs a FIFO depth of 2 or more");
        end
    end

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        logic [15:0] ctrl;
        logic [31:0] cfgRdata;
        logic lps;
        logic oooDisable;
        logic bit9Enable;
        logic outValid;
        logic [TX_WORD_W-1:0] outData;
        logic outLast;
        logic outError;
        logic txUnderrun;
        logic storeForward;
        logic sending;
        logic discarding;
        logic retrySaf;
        logic [BYTE_COUNT_W-1:0] bytesIn;
        logic [PKT_COUNT_W-1:0] pktCount;
    } enh_state_t;

    enh_state_t s;
    enh_state_t next_s;

    tx_fifo_if #(.WIDTH(TX_WORD_W + 1)) fifoBus ();

    tx_fifo #(
        .WIDTH(TX_WORD_W + 1),
        .DEPTH(FIFO_DEPTH)
    ) txFifo (
        .clk(clk),
        .rst(rst),
        .bus(fifoBus.store)
    );

    // ****************************************************************
    // Combinational helpers
    // ****************************************************************
    logic hit;
    logic draftActive;
    logic forceSaf;
    tx_thresh_t threshCode;
    logic stageFree;
    logic doPush;
    logic pushLast;
    logic doPop;
    logic popLast;
    logic startTx;

    assign hit = cfgAddr == LINK_ENH_CTRL_OFFSET;
    assign draftActive = phyEnhanceGate && s.ctrl[DRAFT_ENABLE_BIT];
    assign threshCode = tx_thresh_t'(s.ctrl[TX_THRESH_MSB:TX_THRESH_LSB]);
    // Gate low, retries zero or a pending retry all mean whole packets
    assign forceSaf = !phyEnhanceGate || retriesCleared || s.retrySaf
        || threshCode == THRESH_4K;
    assign stageFree = !s.outValid || outReady;
    assign doPush = inValid && fifoBus.pushReady;
    assign pushLast = doPush && inLast;
    assign doPop = fifoBus.popReady && fifoBus.popValid;
    assign popLast = doPop && fifoBus.popData[TX_WORD_W];
    // Head packet is the one being written when no complete packet waits
    assign startTx = !s.sending && !s.discarding && fifoBus.popValid
        && (s.pktCount != '0
        || (!forceSaf && s.bytesIn >= thresh_bytes(threshCode)));

    assign fifoBus.pushValid = inValid;
    assign fifoBus.pushData = {inLast, inData};
    assign fifoBus.popReady = s.discarding || (s.sending && stageFree);

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        next_s = s;
        next_s.outError = 1'b0;
        next_s.txUnderrun = 1'b0;

        // Register loads; autoload wins over a same-cycle software write
        if (eepromLoad) begin
            next_s.ctrl = eepromData[15:0] & LINK_ENH_CTRL_WR_MASK;
        end else if (cfgWrite && hit && cfgByteEn[1]) begin
            next_s.ctrl[15:8] = cfgWdata[15:8] & LINK_ENH_CTRL_WR_MASK[15:8];
        end
        if (cfgRead) begin
            next_s.cfgRdata = '0;
            if (hit) begin
                // Bit 11 and below are not held here and read as zero
                next_s.cfgRdata = {RESERVED_HIGH_VALUE,
                    s.ctrl & LINK_ENH_CTRL_WR_MASK};
            end
        end

        // Gated effect outputs
        next_s.oooDisable = phyEnhanceGate && s.ctrl[TX_OOO_DISABLE_BIT];
        next_s.bit9Enable = draftActive;
        // Set wins over a clear arriving in the same cycle
        if (lpsSet) begin
            next_s.lps = 1'b1;
        end else if (lpsClearWrite && draftActive) begin
            next_s.lps = 1'b0;
        end

        // Bytes of the packet currently being written
        if (pushLast) begin
            next_s.bytesIn = '0;
        end else if (doPush) begin
            if (s.bytesIn > BYTE_COUNT_MAX - BYTES_PER_WORD) begin
                next_s.bytesIn = BYTE_COUNT_MAX;
            end else begin
                next_s.bytesIn = s.bytesIn + BYTES_PER_WORD;
            end
        end
        next_s.pktCount = s.pktCount + PKT_COUNT_W'(pushLast) - PKT_COUNT_W'(popLast);

        // Link output stage
        if (s.outValid && outReady) begin
            next_s.outValid = 1'b0;
        end
        if (startTx) begin
            next_s.sending = 1'b1;
        end
        if (doPop) begin
            if (s.discarding) begin
                if (popLast) begin
                    next_s.discarding = 1'b0;
                end
            end else begin
                next_s.outValid = 1'b1;
                next_s.outData = fifoBus.popData[TX_WORD_W-1:0];
                next_s.outLast = fifoBus.popData[TX_WORD_W];
                if (popLast) begin
                    next_s.sending = 1'b0;
                    next_s.retrySaf = 1'b0;
                end
            end
        end else if (s.sending && !s.outValid && !fifoBus.popValid) begin
            // Link drained mid-packet: abort, drop the tail, retry whole
            next_s.sending = 1'b0;
            next_s.discarding = 1'b1;
            next_s.outError = 1'b1;
            next_s.txUnderrun = 1'b1;
            next_s.retrySaf = 1'b1;
        end
        next_s.storeForward = forceSaf;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s <= '0;
            s.ctrl <= LINK_ENH_CTRL_RESET[15:0];
            s.storeForward <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign cfgRdata = s.cfgRdata;
    assign linkPowerStatus = s.lps;
    assign txOutOfOrderDisable = s.oooDisable;
    assign rxStatusBit9Enable = s.bit9Enable;
    assign inReady = fifoBus.pushReady;
    assign outValid = s.outValid;
    assign outData = s.outData;
    assign outLast = s.outLast;
    assign outError = s.outError;
    assign txUnderrun = s.txUnderrun;
    assign storeForward = s.storeForward;

endmodule : link_enhancement_control

// *** link_enhancement_control_tb.sv ***
module link_enhancement_control_tb;
    import link_enh_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int DEPTH = 256;
    localparam logic [7:0] A = LINK_ENH_CTRL_OFFSET;
    logic clk = 1'b0, rst, cfgWrite = 1'b0, cfgRead = 1'b0, eepromLoad = 1'b0;
    logic [7:0] cfgAddr = 8'h00;
    logic [3:0] cfgByteEn = 4'h0;
    logic [31:0] cfgWdata = '0, cfgRdata, eepromData = '0, rd, inData = '0, outData;
    logic phyEnhanceGate = 1'b1, retriesCleared = 1'b0, lpsSet = 1'b0, lpsClearWrite = 1'b0;
    logic linkPowerStatus, txOutOfOrderDisable, rxStatusBit9Enable, inReady, outValid;
    logic inValid = 1'b0, inLast = 1'b0, stall = 1'b0;
    logic outReady, outLast, outError, txUnderrun, storeForward;
    int words, packets, w0, p0, n, n_fail = 0, compares = 0;
    always #5 clk = ~clk;
    link_enhancement_control #(.FIFO_DEPTH(DEPTH)) dut (.clk(clk), .rst(rst),
        .cfgWrite(cfgWrite), .cfgRead(cfgRead), .cfgAddr(cfgAddr), .cfgByteEn(cfgByteEn),
        .cfgWdata(cfgWdata), .cfgRdata(cfgRdata), .eepromLoad(eepromLoad),
        .eepromData(eepromData), .phyEnhanceGate(phyEnhanceGate),
        .retriesCleared(retriesCleared), .lpsSet(lpsSet), .lpsClearWrite(lpsClearWrite),
        .linkPowerStatus(linkPowerStatus), .txOutOfOrderDisable(txOutOfOrderDisable),
        .rxStatusBit9Enable(rxStatusBit9Enable), .inValid(inValid), .inReady(inReady),
        .inData(inData), .inLast(inLast), .outValid(outValid), .outReady(outReady),
        .outData(outData), .outLast(outLast), .outError(outError),
        .txUnderrun(txUnderrun), .storeForward(storeForward));
    link_sink sink (.clk(clk), .stall(stall), .outValid(outValid), .outLast(outLast),
        .outReady(outReady), .words(words), .packets(packets));
    // ****************************************
    // Access tasks
    // ****************************************
    task automatic give_verdict();
        $display("compares %0d, mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : give_verdict
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask : tick
    task automatic do_reset();
        rst = 1'b1;
        tick(4);
        rst = 1'b0;
    endtask : do_reset
    // Trailing idle cycle keeps strobes from being set twice in one step
    task automatic cfg_wr(input logic [3:0] be, input logic [31:0] d);
        cfgWrite = 1'b1;
        cfgAddr = A;
        cfgByteEn = be;
        cfgWdata = d;
        tick(1);
        cfgWrite = 1'b0;
        tick(1);
    endtask : cfg_wr
    task automatic cfg_rd(input logic [7:0] a);
        cfgRead = 1'b1;
        cfgAddr = a;
        tick(1);
        cfgRead = 1'b0;
        rd = cfgRdata;
        tick(1);
    endtask : cfg_rd
    task automatic lps_pulse(input logic setIt);
        lpsSet = setIt;
        lpsClearWrite = !setIt;
        tick(1);
        lpsSet = 1'b0;
        lpsClearWrite = 1'b0;
        tick(1);
    endtask : lps_pulse
    task automatic wait_hi(input logic sel);
        n = 0;
        while ((sel ? txUnderrun : outValid) !== 1'b1 && n < 2000) begin
            tick(1);
            n++;
        end
        if (n == 2000) begin
            n_fail++;
            give_verdict();
        end
    endtask : wait_hi
    task automatic send(input int len, input logic [31:0] base, input logic withLast);
        for (int i = 0; i < len; i++) begin
            inValid = 1'b1;
            inData = base + i;
            inLast = withLast && i == len - 1;
            n = 0;
            while (inReady !== 1'b1 && n < 400) begin
                tick(1);
                n++;
            end
            if (n == 400) begin
                n_fail++;
                give_verdict();
            end
            tick(1);
        end
        inValid = 1'b0;
        tick(1);
    endtask : send
    // ****************************************
    // Scenarios
    // ****************************************
    initial begin
        do_reset();
        cfg_rd(A);
        check(rd, LINK_ENH_CTRL_RESET);
        cfg_rd(8'hf8);
        check(rd, 32'h0);
        cfg_wr(4'h0, 32'hffff_ffff);
        cfg_rd(A);
        check(rd, LINK_ENH_CTRL_RESET);
        cfg_wr(4'hf, 32'hffff_ffff);
        cfg_rd(A);
        check(rd, 32'h0000_f000);
        check(txOutOfOrderDisable, 1'b1);
        check(rxStatusBit9Enable, 1'b1);
        phyEnhanceGate = 1'b0;
        tick(2);
        check({txOutOfOrderDisable, rxStatusBit9Enable, storeForward}, 3'b001);
        phyEnhanceGate = 1'b1;
        eepromLoad = 1'b1;
        eepromData = 32'h1234_5abc;
        tick(1);
        eepromLoad = 1'b0;
        cfg_rd(A);
        check(rd, 32'h0000_5000);
        check(txOutOfOrderDisable, 1'b0);
        for (int c = 0; c < 4; c++) begin
            cfg_wr(4'h2, {16'h0, 2'b01, c[1:0], 12'h0});
            cfg_rd(A);
            check(rd[13:12], c[1:0]);
            check(storeForward, c == 0);
        end
        retriesCleared = 1'b1;
        tick(2);
        check(storeForward, 1'b1);
        retriesCleared = 1'b0;
        lps_pulse(1'b1);
        check(linkPowerStatus, 1'b1);
        lps_pulse(1'b0);
        check(linkPowerStatus, 1'b0);
        // 1.7K is the usual choice; 512 here so a cut-through start fits the FIFO
        cfg_wr(4'h2, 32'h0000_3000);
        lps_pulse(1'b1);
        lps_pulse(1'b0);
        check(linkPowerStatus, 1'b1);
        send(127, 32'h100, 1'b0);
        tick(4);
        check(outValid, 1'b0);
        send(1, 32'h17f, 1'b0);
        wait_hi(1'b0);
        check(outData, 32'h100);
        wait_hi(1'b1);
        check(outError, 1'b1);
        w0 = words;
        p0 = packets;
        send(1, 32'h180, 1'b1);
        stall = 1'b1;
        send(2, 32'h200, 1'b0);
        tick(6);
        check(outValid, 1'b0);
        send(1, 32'h202, 1'b1);
        wait_hi(1'b0);
        check(outData, 32'h200);
        stall = 1'b0;
        tick(10);
        check(words - w0, 3);
        check(packets - p0, 1);
        cfg_wr(4'h2, 32'h0);
        // Last flag from the retried packet must not mark these words as whole packets
        inLast = 1'b0;
        inValid = 1'b1;
        n = 0;
        while (inReady === 1'b1 && n < 300) begin
            tick(1);
            n++;
        end
        inValid = 1'b0;
        check(n, DEPTH);
        check(outValid, 1'b0);
        do_reset();
        check(inReady, 1'b1);
        give_verdict();
    end
endmodule : link_enhancement_control_tb

// *** link_sink.sv ***
module link_sink (
    input wire logic clk, // Clock
    input wire logic stall, // Hold off
    input wire logic outValid, // Offered
    input wire logic outLast, // Last word
    output logic outReady, // Taken
    output int words, // Words taken
    output int packets // Packets taken
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        outReady = 1'b0;
        words = 0;
        packets = 0;
    end
    // Ready moves just after the edge, like a real link
    always @(posedge clk) begin
        if (outValid === 1'b1 && outReady === 1'b1) begin
            words <= words + 1;
            packets <= packets + (outLast === 1'b1);
        end
        outReady <= #1 !stall;
    end
endmodule : link_sink

// *** tx_fifo.sv ***
module tx_fifo #(
    parameter int WIDTH = 33,
    parameter int DEPTH = 16
) (
    input wire logic clk, // Host bus clock
    input wire logic rst, // Synchronous reset
    tx_fifo_if.store bus // Push and pop sides
);
    localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CNT_W = $clog2(DEPTH + 1);
    localparam logic [CNT_W-1:0] FULL_COUNT = CNT_W'(DEPTH);

    initial begin
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin
            $error("tx_fifo depth must be a power of two, at least 2");
        end
        if (WIDTH < 1) begin
            $error("tx_fifo width must be positive");
        end
    end

    typedef struct packed {
        logic [PTR_W-1:0] wrPtr;
        logic [PTR_W-1:0] rdPtr;
        logic [CNT_W-1:0] count;
        logic ready;
        logic valid;
    } fifo_state_t;

    fifo_state_t s;
    fifo_state_t next_s;
    logic [WIDTH-1:0] mem [DEPTH];
    logic doPush;
    logic doPop;

    assign doPush = bus.pushValid && s.ready;
    assign doPop = bus.popReady && s.valid;
    assign bus.pushReady = s.ready;
    assign bus.popValid = s.valid;
    assign bus.popData = mem[s.rdPtr];

    always_comb begin
        next_s = s;
        if (doPush) begin
            next_s.wrPtr = s.wrPtr + 1'b1;
        end
        if (doPop) begin
            next_s.rdPtr = s.rdPtr + 1'b1;
        end
        next_s.count = s.count + CNT_W'(doPush) - CNT_W'(doPop);
        // Flags registered so ready and valid come straight from flops
        next_s.ready = next_s.count != FULL_COUNT;
        next_s.valid = next_s.count != '0;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s <= '{wrPtr: '0, rdPtr: '0, count: '0, ready: 1'b1, valid: 1'b0};
        end else begin
            s <= next_s;
        end
    end

    always_ff @(posedge clk) begin
        if (doPush) begin
            mem[s.wrPtr] <= bus.pushData;
        end
    end

endmodule : tx_fifo

// *** tx_fifo_if.sv ***
interface tx_fifo_if #(
    parameter int WIDTH = 33
);
    logic pushValid;
    logic pushReady;
    logic [WIDTH-1:0] pushData;
    logic popValid;
    logic popReady;
    logic [WIDTH-1:0] popData;

    modport writer (
        output pushValid,
        output pushData,
        input pushReady,
        input popValid,
        input popData,
        output popReady
    );

    modport store (
        input pushValid,
        input pushData,
        output pushReady,
        output popValid,
        output popData,
        input popReady
    );
endinterface : tx_fifo_if
